// *** shared/sahp_pkg.sv ***
package sahp_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int BURST_LEN = 4;
  localparam int CNT_W = 8;

  // Configuration bit positions, core side and link side alike
  localparam int CFG_LOWLAT = 0;
  localparam int CFG_BOOT = 1;
  localparam int CFG_BURST = 2;
  localparam int CFG_W = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_XFER = 2'h3,
    ST_TAIL = 2'h2
  } sahp_state_t;

  typedef struct packed {
    sahp_state_t state;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [CNT_W-1:0] cnt;
    logic tail;
    logic rdy;
    logic [DATA_W-1:0] ad_o;
    logic ad_oe;
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [ADDR_W-1:0] hold_addr;
    logic [DATA_W-1:0] hold_data;
    logic req;
  } sahp_link_t;

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic seen;
    logic wr_strobe;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
  } sahp_core_t;

endpackage

// *** shared/sahp_sync_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface sahp_sync_if #(parameter int W = 1) (input wire logic clk);
  logic [W-1:0] d;
  logic [W-1:0] q;
  modport sync (input clk, input d, output q);
  modport user (output d, input q);
endinterface
`default_nettype wire

// *** verilog/sahp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module sahp_sync #(parameter int W = 1) (
  sahp_sync_if.sync port
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sahp_sync_t;

  sahp_sync_t r_q;
  sahp_sync_t r_d;
  logic [W-1:0] agree;

  // Only s2 and s3 are compared; s1 may be metastable
  always_comb begin
    r_d = r_q;
    agree = r_q.s2 ~^ r_q.s3;
    r_d.s1 = port.d;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.q = (agree & r_q.s3) | (~agree & r_q.q);
  end

  // No reset here: this chain also carries the reset into the link domain
  always_ff @(posedge port.clk) begin
    r_q <= r_d;
  end

  assign port.q = r_q.q;
endmodule
`default_nettype wire

// *** verilog/sahp_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// Operation
// RL1 - Host and device launch and sample every port signal on one clock edge.
// RL2 - Host keeps the port clock at or below 100 MHz.
// RL3 - Single read: host sees ready two cycles after output enable asserts.
// RL4 - Single read: ready drops one cycle after the data word appears.
// RL5 - Read data valid two cycles after output enable, held until it releases.
// RL6 - Single write: ready two cycles after write enable, drops three after data edge.
// RL7 - Burst read: first word at two cycles, ready drops after last, last held.
// RL8 - Burst write: ready drops three cycles after the edge taking the last word.
// RL9 - Ready stays high until every word of a started burst is moved.
// RL10 - Host transfer size is a whole multiple of the burst length.
// RL11 - Host holds output enable for the whole burst read, else words lost.
// RL12 - Host holds write enable for the whole burst write, else words lost.
// RL13 - Two-cycle latency normally; optional one-cycle latency below 50 MHz.
// RL14 - During boot only the two-cycle latency is used.
// RL15 - Host may run several accesses while chip enable stays low.
// RL16 - An access ends on the first release of its enable or chip enable.
// RL17 - Address is latched while address valid is low; later phases are data.
module sahp_top #(parameter int BURST_LEN = sahp_pkg::BURST_LEN) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic LOW_LAT_EN,
  input wire logic BOOT_ACTIVE,
  input wire logic BURST_EN,
  output logic WR_STROBE,
  output logic [sahp_pkg::ADDR_W-1:0] WR_ADDR,
  output logic [sahp_pkg::DATA_W-1:0] WR_DATA,
  input wire logic P_CLK,
  input wire logic P_CE_N,
  input wire logic P_ADV_N,
  input wire logic P_OE_N,
  input wire logic P_WE_N,
  input wire logic [sahp_pkg::DATA_W-1:0] P_AD_I,
  output logic [sahp_pkg::DATA_W-1:0] P_AD_O,
  output logic P_AD_OE,
  output logic P_RDY
);
  sahp_pkg::sahp_link_t r_q;
  sahp_pkg::sahp_link_t r_d;
  sahp_pkg::sahp_core_t c_q;
  sahp_pkg::sahp_core_t c_d;

  logic rst_l_n;
  logic [sahp_pkg::CFG_W-1:0] cfg_l;
  logic ack_l;
  logic req_c;
  logic lat1;
  logic sel;
  logic start_rd;
  logic start_wr;
  logic end_c;
  logic free;
  logic [sahp_pkg::CNT_W-1:0] last;

  sahp_sync_if #(.W(sahp_pkg::CFG_W + 1)) cfg_if (.clk(P_CLK));
  sahp_sync_if #(.W(1)) req_if (.clk(CLK));
  sahp_sync_if #(.W(1)) ack_if (.clk(P_CLK));

  sahp_sync #(.W(sahp_pkg::CFG_W + 1)) u_cfg_sync (.port(cfg_if.sync));
  sahp_sync #(.W(1)) u_req_sync (.port(req_if.sync));
  sahp_sync #(.W(1)) u_ack_sync (.port(ack_if.sync));

  assign cfg_if.d = {RESET_N, c_q.cfg};
  assign rst_l_n = cfg_if.q[sahp_pkg::CFG_W];
  assign cfg_l = cfg_if.q[sahp_pkg::CFG_W-1:0];
  assign req_if.d = r_q.req;
  assign req_c = req_if.q;
  assign ack_if.d = c_q.seen;
  assign ack_l = ack_if.q;

  // Boot firmware never runs the reduced latency
  assign lat1 = cfg_l[sahp_pkg::CFG_LOWLAT] & ~cfg_l[sahp_pkg::CFG_BOOT]; // RL13 RL14
  assign last = cfg_l[sahp_pkg::CFG_BURST] ? sahp_pkg::CNT_W'(BURST_LEN - 1) : '0;
  assign sel = ~P_CE_N;
  assign start_rd = sel & ~P_OE_N & P_ADV_N;
  assign start_wr = sel & ~P_WE_N & P_ADV_N & P_OE_N;
  assign end_c = P_CE_N | (r_q.rd ? P_OE_N : P_WE_N);
  assign free = r_q.req == ack_l;

  // Link side: everything on P_CLK rising edge, same edge as the host
  always_comb begin
    r_d = r_q;
    case (r_q.state)
      sahp_pkg::ST_IDLE: begin
        r_d.rdy = 1'h0;
        r_d.ad_oe = 1'h0;
        r_d.cnt = '0;
        r_d.tail = 1'h0;
        if (sel && !P_ADV_N) begin
          r_d.addr = P_AD_I[sahp_pkg::ADDR_W-1:0]; // RL17
        end else if (start_rd || start_wr) begin
          r_d.rd = start_rd;
          r_d.state = lat1 ? sahp_pkg::ST_XFER : sahp_pkg::ST_WAIT; // RL13
          r_d.rdy = lat1;
          r_d.ad_oe = lat1 & start_rd;
          r_d.ad_o = r_q.mem[r_q.addr];
        end
      end
      sahp_pkg::ST_WAIT: begin
        r_d.state = sahp_pkg::ST_XFER;
        r_d.rdy = 1'h1; // RL3 RL6
        r_d.ad_oe = r_q.rd; // RL5 RL7
        r_d.ad_o = r_q.mem[r_q.addr];
      end
      sahp_pkg::ST_XFER: begin
        if (r_q.rd) begin
          if (r_q.cnt == last) begin
            r_d.state = sahp_pkg::ST_TAIL;
            r_d.rdy = 1'h0; // RL4 RL7
          end else begin
            r_d.cnt = r_q.cnt + 1'h1; // RL9
            r_d.addr = r_q.addr + 1'h1;
            r_d.ad_o = r_q.mem[r_q.addr + 1'h1];
          end
        end else begin
          r_d.mem[r_q.addr] = P_AD_I;
          r_d.addr = r_q.addr + 1'h1;
          // Core sees at most one word per handshake; later ones go uncopied
          if (free) begin
            r_d.hold_addr = r_q.addr;
            r_d.hold_data = P_AD_I;
            r_d.req = ~r_q.req;
          end
          if (r_q.cnt == last) begin
            r_d.state = sahp_pkg::ST_TAIL; // RL8 RL9
          end else begin
            r_d.cnt = r_q.cnt + 1'h1;
          end
        end
      end
      sahp_pkg::ST_TAIL: begin
        if (!r_q.rd) begin
          if (r_q.tail) begin
            r_d.rdy = 1'h0; // RL6 RL8
          end else begin
            r_d.tail = 1'h1;
          end
        end
      end
      default: begin
        r_d.state = sahp_pkg::ST_IDLE;
      end
    endcase
    // Early release aborts; words left in the burst are dropped
    if (r_q.state != sahp_pkg::ST_IDLE && end_c) begin
      r_d.state = sahp_pkg::ST_IDLE; // RL16 RL11 RL12
      r_d.rdy = 1'h0;
      r_d.ad_oe = 1'h0;
    end
    if (!rst_l_n) begin
      r_d = '0;
    end
  end

  always_ff @(posedge P_CLK) begin
    r_q <= r_d; // RL1
  end

  // Core side: hold registers are stable while req and ack differ
  always_comb begin
    c_d = c_q;
    c_d.wr_strobe = 1'h0;
    c_d.cfg = {BURST_EN, BOOT_ACTIVE, LOW_LAT_EN};
    if (req_c != c_q.seen) begin
      c_d.seen = req_c;
      c_d.wr_strobe = 1'h1;
      c_d.wr_addr = r_q.hold_addr;
      c_d.wr_data = r_q.hold_data;
    end
    if (!RESET_N) begin
      c_d = '0;
    end
  end

  always_ff @(posedge CLK) begin
    c_q <= c_d;
  end

  assign WR_STROBE = c_q.wr_strobe;
  assign WR_ADDR = c_q.wr_addr;
  assign WR_DATA = c_q.wr_data;
  assign P_AD_O = r_q.ad_o;
  assign P_AD_OE = r_q.ad_oe;
  assign P_RDY = r_q.rdy;

  rd_lat_two_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL3
    (r_q.state == sahp_pkg::ST_IDLE && start_rd && !lat1) ##1 (!P_OE_N && !P_CE_N)
    |=> P_RDY && P_AD_OE) else $error("read ready not two cycles after enable");
  rd_lat_one_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL13
    r_q.state == sahp_pkg::ST_IDLE && start_rd && lat1 |=> P_RDY)
    else $error("one cycle latency not honoured");
  boot_lat_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL14
    cfg_l[sahp_pkg::CFG_BOOT] && r_q.state == sahp_pkg::ST_IDLE && (start_rd || start_wr)
    |=> !P_RDY) else $error("reduced latency used during boot");
  rd_rdy_drop_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL4
    r_q.state == sahp_pkg::ST_XFER && r_q.rd && r_q.cnt == last && !end_c
    |=> !P_RDY && P_AD_OE) else $error("read ready not dropped after last word");
  rd_data_hold_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL5 RL7
    r_q.state == sahp_pkg::ST_TAIL && r_q.rd && !end_c
    |=> $stable(P_AD_O) && P_AD_OE) else $error("read data not held");
  wr_rdy_start_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL6
    (r_q.state == sahp_pkg::ST_IDLE && start_wr && !lat1) ##1 (!P_WE_N && !P_CE_N)
    |=> P_RDY) else $error("write ready not two cycles after enable");
  wr_tail_on_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL8
    (r_q.state == sahp_pkg::ST_XFER && !r_q.rd && r_q.cnt == last && !end_c)
    ##1 (!P_WE_N && !P_CE_N) |-> P_RDY) else $error("write ready dropped early");
  wr_tail_off_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL6 RL8
    (r_q.state == sahp_pkg::ST_XFER && !r_q.rd && r_q.cnt == last && !end_c)
    ##1 (!P_WE_N && !P_CE_N) [*2] |=> !P_RDY) else $error("write ready late to drop");
  burst_rdy_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL9
    r_q.state == sahp_pkg::ST_XFER |-> P_RDY) else $error("ready low inside burst");
  addr_latch_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL17
    r_q.state == sahp_pkg::ST_IDLE && sel && !P_ADV_N
    |=> r_q.addr == $past(P_AD_I[sahp_pkg::ADDR_W-1:0])) else $error("address not latched");
  early_end_a: assert property (@(posedge P_CLK) disable iff (!rst_l_n) // RL16
    r_q.state != sahp_pkg::ST_IDLE && end_c |=> !P_RDY && !P_AD_OE
    && r_q.state == sahp_pkg::ST_IDLE) else $error("access not ended on release");

  rd_burst_c: cover property (@(posedge P_CLK) disable iff (!rst_l_n)
    r_q.state == sahp_pkg::ST_XFER && r_q.rd && r_q.cnt == last && last != '0);
  wr_burst_c: cover property (@(posedge P_CLK) disable iff (!rst_l_n)
    r_q.state == sahp_pkg::ST_TAIL && !r_q.rd && r_q.tail);
  abort_c: cover property (@(posedge P_CLK) disable iff (!rst_l_n)
    r_q.state == sahp_pkg::ST_XFER && end_c);
  core_wr_c: cover property (@(posedge CLK) disable iff (!RESET_N) c_q.wr_strobe);
endmodule
`default_nettype wire

// *** test/sahp_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module sahp_host (
  input wire logic p_clk,
  input wire logic rdy,
  input wire logic ad_oe,
  input wire logic [15:0] ad_o,
  output var logic ce_n,
  output var logic adv_n,
  output var logic oe_n,
  output var logic we_n,
  output wire logic [15:0] ad_i
);
  logic h_oe = 1'h0;
  logic [15:0] h_ad = 16'h0000;
  // A released bus shows the inverse of the host word h_ad, not a stale copy
  assign ad_i = ad_oe ? ad_o : (h_oe ? h_ad : ~h_ad);
  initial {ce_n, adv_n, oe_n, we_n} = 4'hF;
  task automatic xfer(input logic wr, input logic [3:0] a, input int n, input int stop,
      input logic keep, inout logic [63:0] d, output logic [15:0] lat,
      output logic [15:0] tail, output logic [15:0] hold);
    int k = 0;
    lat = 16'h0000;
    tail = 16'h0000;
    @(posedge p_clk);
    {ce_n, adv_n, h_oe} <= 3'h1;
    h_ad <= {12'h000, a};
    @(posedge p_clk);
    {adv_n, oe_n, we_n, h_oe} <= {1'h1, wr, !wr, wr};
    h_ad <= d[15:0];
    @(posedge p_clk);
    do begin
      @(posedge p_clk);
      lat++;
    end while (rdy !== 1'h1 && lat < 16'h0008);
    while (rdy === 1'h1 && k < stop) begin
      if (!wr)
        d[16*k +: 16] = ad_o;
      k++;
      h_ad <= d[16*(k%4) +: 16];
      h_oe <= wr && k < n;
      if (k == stop && stop < n)
        {oe_n, we_n} <= 2'h3;
      @(posedge p_clk);
    end
    while (rdy === 1'h1 && tail < 16'h0008) begin
      tail++;
      @(posedge p_clk);
    end
    hold = ad_oe ? ad_o : ~ad_o;
    // Chip enable may stay low so the next access follows without a gap
    {ce_n, oe_n, we_n, h_oe} <= {!keep, 3'h6};
    repeat (3) @(posedge p_clk);
  endtask
endmodule
`default_nettype wire

// *** test/tb_sync_muxed_addr_data_bus_host_port.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_sync_muxed_addr_data_bus_host_port;
  logic clk = 1'h0, p_clk = 1'h0, reset_n = 1'h0;
  logic low_lat = 1'h0, boot = 1'h0, burst = 1'h0;
  logic wr_strobe, ad_oe, rdy, ce_n, adv_n, oe_n, we_n;
  logic [3:0] wr_addr, st_addr;
  logic [15:0] wr_data, st_data, ad_i, ad_o, lat, tail, hold;
  logic [63:0] d;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int strobes = 0;
  sahp_top #(.BURST_LEN(4)) dut (
    .CLK(clk), .RESET_N(reset_n), .LOW_LAT_EN(low_lat), .BOOT_ACTIVE(boot),
    .BURST_EN(burst), .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
    .P_CLK(p_clk), .P_CE_N(ce_n), .P_ADV_N(adv_n), .P_OE_N(oe_n), .P_WE_N(we_n),
    .P_AD_I(ad_i), .P_AD_O(ad_o), .P_AD_OE(ad_oe), .P_RDY(rdy));
  sahp_host host (.p_clk(p_clk), .rdy(rdy), .ad_oe(ad_oe), .ad_o(ad_o), .ce_n(ce_n),
    .adv_n(adv_n), .oe_n(oe_n), .we_n(we_n), .ad_i(ad_i));
  initial forever #50 clk = ~clk;
  // Odd offset keeps link edges clear of core edges
  initial #37 forever #40 p_clk = ~p_clk;
  always @(posedge clk) begin
    cycles++;
    if (wr_strobe === 1'h1) begin
      strobes++;
      st_data <= wr_data;
      st_addr <= wr_addr;
    end
    if (cycles == 3000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cfg(input logic ll, input logic bt, input logic bu);
    @(posedge clk);
    low_lat <= ll;
    boot <= bt;
    burst <= bu;
    repeat (8) @(posedge clk);
    d = 64'h0;
  endtask
  task automatic t_single;
    cfg(1'h0, 1'h0, 1'h0);
    d[15:0] = 16'hA5C3;
    host.xfer(1'h1, 4'h3, 1, 1, 1'h0, d, lat, tail, hold);
    chk("wr lat", 16'h0002, lat);
    chk("wr tail", 16'h0002, tail);
    repeat (8) @(posedge clk);
    chk("core data", 16'hA5C3, st_data);
    chk("core addr", 16'h0003, {12'h000, st_addr});
    chk("core strobes", 16'h0001, strobes[15:0]);
    d = 64'h0;
    host.xfer(1'h0, 4'h3, 1, 1, 1'h0, d, lat, tail, hold);
    chk("rd lat", 16'h0002, lat);
    chk("rd tail", 16'h0000, tail);
    chk("rd data", 16'hA5C3, d[15:0]);
    chk("rd hold", 16'hA5C3, hold);
    $display("single access test done");
  endtask
  task automatic t_burst;
    cfg(1'h0, 1'h0, 1'h1);
    d = 64'h4D44_3C33_2B22_1A11;
    host.xfer(1'h1, 4'hE, 4, 4, 1'h0, d, lat, tail, hold);
    chk("bwr tail", 16'h0002, tail);
    d = 64'h0;
    host.xfer(1'h0, 4'hE, 4, 4, 1'h0, d, lat, tail, hold);
    chk("bcore data", 16'h1A11, st_data);
    chk("bcore addr", 16'h000E, {12'h000, st_addr});
    chk("brd lat", 16'h0002, lat);
    for (int i = 0; i < 4; i++)
      chk("brd word", 16'h1A11 + 16'h1111 * i[15:0], d[16*i +: 16]);
    chk("brd tail", 16'h0000, tail);
    chk("brd hold", 16'h4D44, hold);
    $display("burst test done");
  endtask
  task automatic t_latency;
    cfg(1'h1, 1'h1, 1'h0);
    host.xfer(1'h0, 4'h3, 1, 1, 1'h0, d, lat, tail, hold);
    chk("boot lat", 16'h0002, lat);
    chk("boot data", 16'hA5C3, d[15:0]);
    cfg(1'h1, 1'h0, 1'h0);
    d[15:0] = 16'h7E81;
    host.xfer(1'h1, 4'h5, 1, 1, 1'h0, d, lat, tail, hold);
    chk("short wr lat", 16'h0001, lat);
    chk("short wr tail", 16'h0002, tail);
    d = 64'h0;
    host.xfer(1'h0, 4'h3, 1, 1, 1'h0, d, lat, tail, hold);
    chk("short lat", 16'h0001, lat);
    chk("short tail", 16'h0000, tail);
    chk("short data", 16'hA5C3, d[15:0]);
    host.xfer(1'h0, 4'h5, 1, 1, 1'h0, d, lat, tail, hold);
    chk("short back", 16'h7E81, d[15:0]);
    $display("latency test done");
  endtask
  task automatic t_chain;
    cfg(1'h0, 1'h0, 1'h0);
    d[15:0] = 16'h3C96;
    host.xfer(1'h1, 4'h9, 1, 1, 1'h1, d, lat, tail, hold);
    chk("chain wr lat", 16'h0002, lat);
    d = 64'h0;
    host.xfer(1'h0, 4'h9, 1, 1, 1'h0, d, lat, tail, hold);
    chk("chain rd lat", 16'h0002, lat);
    chk("chain data", 16'h3C96, d[15:0]);
    $display("chain test done");
  endtask
  task automatic t_abort;
    cfg(1'h0, 1'h0, 1'h1);
    host.xfer(1'h0, 4'hE, 4, 2, 1'h0, d, lat, tail, hold);
    chk("abort word", 16'h2B22, d[31:16]);
    chk("abort tail", 16'h0001, tail);
    $display("abort test done");
  endtask
  // Held longer than the first reset so the link reset has crossed back
  task automatic t_reset;
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (12) @(posedge clk);
    chk("rst strobe", 16'h0000, {15'h0000, wr_strobe});
    chk("rst addr", 16'h0000, {12'h000, wr_addr});
    chk("rst data", 16'h0000, wr_data);
    chk("rst port", 16'h0000, {14'h0000, rdy, ad_oe});
    chk("rst bus", 16'h0000, ad_o);
    reset_n <= 1'h1;
    cfg(1'h0, 1'h0, 1'h0);
    d = 64'hFFFF;
    host.xfer(1'h0, 4'h3, 1, 1, 1'h0, d, lat, tail, hold);
    chk("rst lat", 16'h0002, lat);
    chk("rst mem", 16'h0000, d[15:0]);
    $display("reset test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    t_single();
    t_burst();
    t_latency();
    t_chain();
    t_abort();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
